// ### iam_top.v
// Two-wire byte interface: APB registers, master transmitter, slave address match, flag handshake
`timescale 1ns/1ps
`include "iam_map.vh"

// Function
// (RULE_01) Own 7-bit address sits in the top seven address-register bits; used as slave only.
// (RULE_02) Address-register bit 0 enables general call address zero recognition.
// (RULE_03) Comparator checks received address against own address and general call; match raises request.
// (RULE_04) Operation-complete flag rises after every bus event, byte or START; code sets it only for own START, master bytes and a slave address match.
// (RULE_05) Flag requests interrupt only with local and global enables both set.
// (RULE_06) With local enable clear, software polls the flag.
// (RULE_07) While the flag is set, status shows a code for bus and interface state.
// (RULE_08) Writing one to the flag bit clears it; zero leaves it.
// (RULE_09) No bus operation while flag set; requested operation starts right after clearing.
// (RULE_10) After a sent START, flag rises with a START-sent status code.
// (RULE_11) Software checks START code, loads address plus write bit, clears flag.
// (RULE_12) After an address byte, flag rises and status tells whether it was acknowledged.
// (RULE_13) After a data byte, flag rises and status tells whether it was acknowledged.
// (RULE_14) A software-requested STOP does not set the flag.
// (RULE_15) Clock line held low while the flag is set.
// (RULE_16) Software finishes register updates before writing control with the flag bit.
// (RULE_17) One data register supplies both address and data bytes.
// (RULE_18) A master that may be addressed must have its own address programmed.
// (RULE_19) Status holds 5-bit code in bits 7..3 and prescaler in bits 1..0.
// (RULE_20) With acknowledge enabled, a general call is acknowledged only if recognition is enabled; code also acks it when own address bits 7..1 are 0.
// (RULE_21) Status code values are block parameters.
module iam_top #(
  parameter [4:0] ST_IDLE = 5'h1F, // RULE_21
  parameter [4:0] ST_START = 5'h01,
  parameter [4:0] ST_ADDR_ACK = 5'h02,
  parameter [4:0] ST_ADDR_NACK = 5'h03,
  parameter [4:0] ST_DATA_ACK = 5'h04,
  parameter [4:0] ST_DATA_NACK = 5'h05,
  parameter [4:0] ST_OWN_ADDR = 5'h06,
  parameter [4:0] ST_GEN_CALL = 5'h07
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Interrupt request
  input wire glb_irq_en,
  output wire irq,
  // Serial clock pin
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  // Serial data pin
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe
);

  localparam [2:0] M_IDLE = 3'd0;
  localparam [2:0] M_START = 3'd1;
  localparam [2:0] M_BIT = 3'd2;
  localparam [2:0] M_HOLD = 3'd3;
  localparam [2:0] M_STOP = 3'd4;
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_ADDR = 2'd1;
  localparam [1:0] S_ACK = 2'd2;
  localparam [1:0] S_HOLD = 2'd3;
  localparam integer QTR_CYC = `IAM_QTR_CYC;
  localparam [7:0] QTR_M1 = QTR_CYC[7:0] - 8'h01;
  localparam [7:0] RST_CTRL = `IAM_RST_CTRL;

  // Software-visible state
  reg flag_r;
  reg ack_en_r;
  reg sta_r;
  reg sto_r;
  reg wc_r;
  reg en_r;
  reg ie_r;
  reg [4:0] code_r;
  reg [1:0] ps_r;
  reg [7:0] data_r;
  reg [7:0] own_r;
  reg [31:0] prdata_r;
  reg irq_r;

  // Master state
  reg [2:0] m_st_r;
  reg [1:0] ph_r;
  reg [3:0] bc_r;
  reg [7:0] tx_sh_r;
  reg [7:0] rx_sh_r;
  reg first_r;
  reg m_scl_low_r;
  reg m_sda_low_r;
  reg m_done_r;
  reg [4:0] m_code_r;
  reg sto_clr_r;
  reg [7:0] qcnt_r;

  // Slave state
  reg [1:0] s_st_r;
  reg [3:0] sbc_r;
  reg [7:0] s_sh_r;
  reg s_gc_r;
  reg s_scl_low_r;
  reg s_sda_low_r;
  reg s_done_r;
  reg [4:0] s_code_r;
  reg busy_r;
  reg scl_q_r;
  reg sda_q_r;

  wire [1:0] lvl;
  wire scl_f;
  wire sda_f;
  wire hit;
  wire gc_hit;
  wire tick;
  wire wr_acc;
  wire rd_setup;
  wire addr_ok;
  wire ctrl_wr;
  wire data_wr;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  iam_sync #(.W(2)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({scl_i, sda_i}),
    .lvl_out(lvl)
  );
  assign scl_f = lvl[1];
  assign sda_f = lvl[0];

  iam_addr_cmp u_cmp (
    .rx_byte(s_sh_r),
    .own_addr(own_r),
    .hit(hit),
    .gc_hit(gc_hit)
  );

  // APB decode; reads are sampled in the setup cycle so prdata comes from a flop
  assign addr_ok = (paddr == `IAM_OFF_CTRL) | (paddr == `IAM_OFF_STAT) |
                   (paddr == `IAM_OFF_DATA) | (paddr == `IAM_OFF_ADDR);
  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable;
  assign ctrl_wr = wr_acc & (paddr == `IAM_OFF_CTRL);
  assign data_wr = wr_acc & (paddr == `IAM_OFF_DATA);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        `IAM_OFF_CTRL: prdata_r <= {24'h00_0000, flag_r, ack_en_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
        `IAM_OFF_STAT: prdata_r <= {24'h00_0000, code_r, 1'b0, ps_r}; // RULE_19
        `IAM_OFF_DATA: prdata_r <= {24'h00_0000, data_r};
        `IAM_OFF_ADDR: prdata_r <= {24'h00_0000, own_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Control, address and prescaler registers
  always @(posedge clk) begin
    if (sys_rst) begin
      ack_en_r <= RST_CTRL[`IAM_CTRL_ACK_EN];
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
      own_r <= `IAM_RST_ADDR;
      ps_r <= `IAM_RST_PS;
    end else begin
      if (ctrl_wr) begin
        ack_en_r <= pwdata[`IAM_CTRL_ACK_EN];
        sta_r <= pwdata[`IAM_CTRL_STA];
        en_r <= pwdata[`IAM_CTRL_EN];
        ie_r <= pwdata[`IAM_CTRL_IE];
      end
      // Hardware clears the stop request once it is executed
      if (sto_clr_r) begin
        sto_r <= 1'b0;
      end else if (ctrl_wr) begin
        sto_r <= pwdata[`IAM_CTRL_STO];
      end
      if (wr_acc && paddr == `IAM_OFF_ADDR) begin
        own_r <= pwdata[7:0]; // RULE_01
      end
      if (wr_acc && paddr == `IAM_OFF_STAT) begin
        ps_r <= pwdata[`IAM_STAT_PS_MSB:`IAM_STAT_PS_LSB];
      end
    end
  end

  // Flag and status: a completing event wins over a software clear in the same cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
      code_r <= ST_IDLE;
    end else if (m_done_r) begin
      flag_r <= 1'b1; // RULE_04
      code_r <= m_code_r; // RULE_07
    end else if (s_done_r) begin
      flag_r <= 1'b1; // RULE_03
      code_r <= s_code_r; // RULE_07
    end else if (ctrl_wr && pwdata[`IAM_CTRL_FLAG]) begin
      flag_r <= 1'b0; // RULE_08
      code_r <= ST_IDLE;
    end
  end

  // Data register holds the next byte out or the last byte seen; writes are legal only while flag is set
  always @(posedge clk) begin
    if (sys_rst) begin
      data_r <= `IAM_RST_DATA;
      wc_r <= 1'b0;
    end else if (m_done_r && m_code_r != ST_START) begin
      data_r <= rx_sh_r;
    end else if (s_done_r) begin
      data_r <= s_sh_r;
    end else if (data_wr) begin
      if (flag_r) begin
        data_r <= pwdata[7:0]; // RULE_17
        wc_r <= 1'b0;
      end else begin
        wc_r <= 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r & ie_r & glb_irq_en; // RULE_05
    end
  end
  assign irq = irq_r;

  // Quarter-bit enable; bit rate is fixed since rate programming is outside this unit
  always @(posedge clk) begin
    if (sys_rst || qcnt_r == QTR_M1) begin
      qcnt_r <= 8'h00;
    end else begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end
  assign tick = (qcnt_r == QTR_M1);

  // Master transmitter: START, byte with acknowledge, STOP
  always @(posedge clk) begin
    if (sys_rst || !en_r) begin
      m_st_r <= M_IDLE;
      ph_r <= 2'd0;
      bc_r <= 4'd0;
      tx_sh_r <= 8'h00;
      rx_sh_r <= 8'h00;
      first_r <= 1'b0;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
      m_done_r <= 1'b0;
      m_code_r <= ST_IDLE;
      sto_clr_r <= 1'b0;
    end else begin
      m_done_r <= 1'b0;
      sto_clr_r <= 1'b0;
      if (tick) begin
        case (m_st_r)
          M_IDLE: begin
            // Wait for a free bus before claiming it
            if (sta_r && !flag_r && !busy_r) begin // RULE_09
              m_st_r <= M_START;
              ph_r <= 2'd0;
            end
          end
          M_HOLD: begin
            if (!flag_r) begin // RULE_09
              ph_r <= 2'd0;
              if (sto_r) begin
                m_st_r <= M_STOP;
              end else if (sta_r) begin
                m_st_r <= M_START;
              end else begin
                m_st_r <= M_BIT;
                bc_r <= 4'd0;
                tx_sh_r <= data_r; // RULE_17
              end
            end
          end
          M_START: begin
            ph_r <= ph_r + 2'd1;
            case (ph_r)
              2'd0: m_sda_low_r <= 1'b0;
              2'd1: m_scl_low_r <= 1'b0;
              2'd2: m_sda_low_r <= 1'b1;
              default: begin
                m_scl_low_r <= 1'b1;
                m_done_r <= 1'b1; // RULE_10
                m_code_r <= ST_START;
                first_r <= 1'b1;
                m_st_r <= M_HOLD;
              end
            endcase
          end
          M_BIT: begin
            ph_r <= ph_r + 2'd1;
            case (ph_r)
              2'd0: m_sda_low_r <= (bc_r == 4'd8) ? 1'b0 : ~tx_sh_r[7];
              2'd1: m_scl_low_r <= 1'b0;
              2'd2: begin
                if (bc_r != 4'd8) begin
                  rx_sh_r <= {rx_sh_r[6:0], sda_f};
                end
              end
              default: begin
                m_scl_low_r <= 1'b1;
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                if (bc_r == 4'd8) begin
                  m_done_r <= 1'b1;
                  first_r <= 1'b0;
                  m_st_r <= M_HOLD;
                  // A low data line in the ninth bit is an acknowledge
                  if (first_r) begin
                    m_code_r <= sda_f ? ST_ADDR_NACK : ST_ADDR_ACK; // RULE_12
                  end else begin
                    m_code_r <= sda_f ? ST_DATA_NACK : ST_DATA_ACK; // RULE_13
                  end
                end else begin
                  bc_r <= bc_r + 4'd1;
                end
              end
            endcase
          end
          M_STOP: begin
            ph_r <= ph_r + 2'd1;
            case (ph_r)
              2'd0: m_sda_low_r <= 1'b1;
              2'd1: m_scl_low_r <= 1'b0;
              2'd2: m_sda_low_r <= 1'b0;
              default: begin
                m_st_r <= M_IDLE; // RULE_14
                sto_clr_r <= 1'b1;
              end
            endcase
          end
          default: m_st_r <= M_IDLE;
        endcase
      end
    end
  end

  // Bus edge and condition detection on filtered levels
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign start_det = scl_f & scl_q_r & ~sda_f & sda_q_r;
  assign stop_det = scl_f & scl_q_r & sda_f & ~sda_q_r;

  // Slave address receiver; only listens while not acting as master
  always @(posedge clk) begin
    if (sys_rst || !en_r) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      busy_r <= 1'b0;
      s_st_r <= S_IDLE;
      sbc_r <= 4'd0;
      s_sh_r <= 8'h00;
      s_gc_r <= 1'b0;
      s_scl_low_r <= 1'b0;
      s_sda_low_r <= 1'b0;
      s_done_r <= 1'b0;
      s_code_r <= ST_IDLE;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      s_done_r <= 1'b0;
      if (start_det) begin
        busy_r <= 1'b1;
      end else if (stop_det) begin
        busy_r <= 1'b0;
      end
      if (m_st_r != M_IDLE || (sto_r && s_st_r != S_IDLE)) begin
        // Own master cycle, or software recovery to unaddressed slave
        s_st_r <= S_IDLE;
        s_scl_low_r <= 1'b0;
        s_sda_low_r <= 1'b0;
      end else if (start_det) begin
        s_st_r <= S_ADDR;
        sbc_r <= 4'd0;
        s_sda_low_r <= 1'b0;
      end else if (stop_det) begin
        s_st_r <= S_IDLE;
        s_sda_low_r <= 1'b0;
      end else begin
        case (s_st_r)
          S_ADDR: begin
            if (scl_rise && sbc_r != 4'd8) begin
              s_sh_r <= {s_sh_r[6:0], sda_f};
              sbc_r <= sbc_r + 4'd1;
            end else if (scl_fall && sbc_r == 4'd8) begin
              if (hit && ack_en_r) begin // RULE_20
                // Pin filter lags a fast master, so stretch the low phase until the acknowledge is driven
                s_scl_low_r <= 1'b1;
                s_sda_low_r <= 1'b1;
                s_gc_r <= gc_hit;
                s_st_r <= S_ACK;
              end else begin
                s_st_r <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            if (s_scl_low_r) begin
              s_scl_low_r <= 1'b0;
            end else if (scl_fall) begin
              s_sda_low_r <= 1'b0;
              s_scl_low_r <= 1'b1; // RULE_15
              s_done_r <= 1'b1; // RULE_03
              s_code_r <= s_gc_r ? ST_GEN_CALL : ST_OWN_ADDR;
              s_st_r <= S_HOLD;
            end
          end
          S_HOLD: begin
            // Flag rises one cycle after the done pulse, so skip that cycle
            if (!flag_r && !s_done_r) begin // RULE_15
              s_scl_low_r <= 1'b0;
              s_st_r <= S_IDLE;
            end
          end
          default: s_st_r <= S_IDLE;
        endcase
      end
    end
  end

  // Open-drain pins: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = m_scl_low_r | s_scl_low_r; // RULE_15
  assign sda_oe = m_sda_low_r | s_sda_low_r;

endmodule // iam_top

// ### iam_map.vh
// Register map, field positions, reset values and bus timing for the address-match unit
`ifndef IAM_MAP_VH
`define IAM_MAP_VH

// Register byte offsets on APB
`define IAM_OFF_CTRL 8'h00
`define IAM_OFF_STAT 8'h04
`define IAM_OFF_DATA 8'h08
`define IAM_OFF_ADDR 8'h0C

// Control register fields
`define IAM_CTRL_FLAG 7
`define IAM_CTRL_ACK_EN 6
`define IAM_CTRL_STA 5
`define IAM_CTRL_STO 4
`define IAM_CTRL_WC 3
`define IAM_CTRL_EN 2
`define IAM_CTRL_IE 0

// Status register fields
`define IAM_STAT_CODE_MSB 7
`define IAM_STAT_CODE_LSB 3
`define IAM_STAT_PS_MSB 1
`define IAM_STAT_PS_LSB 0

// Own address register fields
`define IAM_ADDR_MSB 7
`define IAM_ADDR_LSB 1
`define IAM_ADDR_GCE 0

// Reset values
`define IAM_RST_CTRL 8'h00
`define IAM_RST_DATA 8'hFF
`define IAM_RST_ADDR 8'h00
`define IAM_RST_PS 2'h0

// Timing: quarter of a serial bit at 100 kHz, on a 50 ns system clock
`define IAM_CLK_NS 50
`define IAM_QTR_NS 2500
`define IAM_QTR_CYC ((`IAM_QTR_NS + `IAM_CLK_NS - 1) / `IAM_CLK_NS)

`endif

// ### iam_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module iam_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Pins in, filtered levels out
  input wire [W-1:0] pin_in,
  output wire [W-1:0] lvl_out
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      // Idle bus lines float high, so reset to one
      always @(posedge clk) begin
        if (sys_rst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s2_r;
          end
        end
      end
      assign lvl_out[i] = lvl_r;
    end
  endgenerate

endmodule // iam_sync

// ### iam_addr_cmp.v
// Received serial address against own address and general call
`timescale 1ns/1ps
`include "iam_map.vh"
module iam_addr_cmp (
  // Received address byte
  input wire [7:0] rx_byte,
  // Own address register
  input wire [7:0] own_addr,
  // Match results
  output wire hit,
  output wire gc_hit
);

  // General call is only seen while its enable bit is set
  assign gc_hit = own_addr[`IAM_ADDR_GCE] & (rx_byte == 8'h00); // RULE_02
  assign hit = (rx_byte[7:1] == own_addr[`IAM_ADDR_MSB:`IAM_ADDR_LSB]) | gc_hit; // RULE_03

endmodule // iam_addr_cmp

// ### iam_top_asserts.sv
// Port-level assertions for the two-wire byte interface top
`timescale 1ns/1ps
`include "iam_map.vh"
module iam_top_asserts (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Interrupt request
  input wire glb_irq_en,
  input wire irq,
  // Serial pins
  input wire scl_i,
  input wire scl_o,
  input wire scl_oe,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable;
  wire mapped = (paddr == `IAM_OFF_CTRL) || (paddr == `IAM_OFF_STAT) || (paddr == `IAM_OFF_DATA) ||
    (paddr == `IAM_OFF_ADDR);
  // STOP signature: data released while the clock line is high and not pulled by us
  wire stop_seen = !sda_oe && !scl_oe && scl_i;

  chk_ready_high: assert property (pready) else $error("pready low");
  chk_rdata_upper: assert property (prdata[31:8] == 24'h0000_00) else $error("prdata upper bits set");
  chk_read_hold: assert property (acc |=> $stable(prdata)) else $error("prdata moved after access phase");
  chk_slverr_map: assert property (pslverr == (acc && !mapped)) else $error("pslverr mismatch");
  chk_pins_low: assert property (!scl_o && !sda_o) else $error("pin output not zero");
  chk_idle_reset: assert property ($fell(sys_rst) |-> !scl_oe && !sda_oe) else $error("lines held after reset");
  chk_irq_gate: assert property (irq |-> $past(glb_irq_en)) else $error("irq without global enable");
  chk_irq_scl_held: assert property ($rose(irq) |-> scl_oe) else $error("flag without clock stretch");
  chk_start_seq: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:60] scl_oe) else $error("start not closed");
  chk_stop_quiet: assert property ($fell(sda_oe) && stop_seen |=> !scl_oe [*8]) else $error("stretch after stop");

  cover property ($rose(irq));
  cover property (pslverr);
  cover property ($fell(sda_oe) && stop_seen);
endmodule // iam_top_asserts

bind iam_top iam_top_asserts iam_top_asserts_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .glb_irq_en(glb_irq_en), .irq(irq), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe));

// ### iam_peer.sv
// Far-side bus party: slave acknowledging its own address, plus task-driven master
`timescale 1ns/1ps
module iam_peer #(
  parameter [6:0] ADDR = 7'h51
) (
  // Wired bus levels
  input wire scl,
  input wire sda,
  // Open-drain pulls, high pulls the line low
  output reg scl_low,
  output wire sda_low,
  // Last byte seen on the bus
  output reg [7:0] rx_byte
);
  reg [7:0] sh;
  reg [3:0] bitn;
  reg first;
  reg addressed;
  reg s_ack;
  reg m_sda;
  assign sda_low = m_sda | s_ack;
  initial begin
    scl_low = 1'b0;
    m_sda = 1'b0;
    s_ack = 1'b0;
    rx_byte = 8'h00;
    sh = 8'h00;
    bitn = 4'hF;
    first = 1'b0;
    addressed = 1'b0;
  end
  always @(negedge sda) if (scl) begin
    bitn = 4'h0;
    first = 1'b1;
  end
  always @(posedge sda) if (scl) begin
    addressed = 1'b0;
    bitn = 4'hF;
  end
  // Bits are taken MSB first on rising clock
  always @(posedge scl) if (bitn < 4'h8) begin
    sh = {sh[6:0], sda};
    bitn = bitn + 4'h1;
  end
  always @(negedge scl) begin
    if (bitn == 4'h8) begin
      rx_byte = sh;
      if (first ? (sh[7:1] == ADDR) : addressed) begin
        s_ack = 1'b1;
        addressed = addressed | first;
      end
      first = 1'b0;
      bitn = 4'h9;
    end else if (bitn == 4'h9) begin
      s_ack = 1'b0;
      bitn = 4'h0;
    end
  end
  // START, eight bits and the ack clock; leaves both lines low. Offset keeps edges off the system clock
  task send(input [7:0] b, output ack);
    integer i;
    begin
      #13 m_sda = 1'b1;
      #200;
      for (i = 8; i >= 0; i = i - 1) begin
        scl_low = 1'b1;
        #100 m_sda = (i == 0) ? 1'b0 : !b[i-1];
        #100 scl_low = 1'b0;
        wait (scl);
        #100 if (i == 0) ack = !sda;
        #100;
      end
      scl_low = 1'b1;
      #100 m_sda = 1'b1;
    end
  endtask
  // Waits out any clock stretch before the STOP
  task stop;
    begin
      #100 scl_low = 1'b0;
      wait (scl);
      #200 m_sda = 1'b0;
      #200;
    end
  endtask
endmodule // iam_peer

// ### iam_top_tb.sv
// Self-checking bench: APB register access, master transfers and slave address match
`timescale 1ns/1ps
`include "iam_map.vh"
module iam_top_tb;
  localparam [4:0] C_START = 5'h01;
  localparam [4:0] C_AACK = 5'h02;
  localparam [4:0] C_ANACK = 5'h03;
  localparam [4:0] C_DACK = 5'h04;
  localparam [4:0] C_OWN = 5'h06;
  localparam [4:0] C_GC = 5'h07;
  reg clk, sys_rst, psel, penable, pwrite, glb_irq_en;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda;
  wire [7:0] p_byte;
  // Pull-ups: a released line reads high
  wire scl = !scl_oe && !p_scl;
  wire sda = !sda_oe && !p_sda;
  integer failures, num_checks, i;
  reg [7:0] q;
  reg err, ack;

  iam_top #(.ST_START(C_START), .ST_ADDR_ACK(C_AACK), .ST_ADDR_NACK(C_ANACK), .ST_DATA_ACK(C_DACK),
    .ST_OWN_ADDR(C_OWN), .ST_GEN_CALL(C_GC)) iam_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .glb_irq_en(glb_irq_en), .irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  iam_peer #(.ADDR(7'h51)) iam_peer_inst (.scl(scl), .sda(sda), .scl_low(p_scl), .sda_low(p_sda), .rx_byte(p_byte));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task close_out;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk8(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // Entered just after a rising edge; returns one edge after release
  task apb(input w, input [7:0] a, input [7:0] d);
    integer n;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0000_00, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wait_flag;
    integer n;
    begin
      n = 0;
      apb(1'b0, `IAM_OFF_CTRL, 8'h00);
      while (q[7] !== 1'b1 && n < 3000) begin
        n = n + 1;
        apb(1'b0, `IAM_OFF_CTRL, 8'h00);
      end
      chk1(q[7], 1'b1);
    end
  endtask
  task slave_case(input [7:0] own, input [7:0] ctl, input [7:0] b, input exp, input [4:0] code);
    begin
      apb(1'b1, `IAM_OFF_ADDR, own);
      apb(1'b1, `IAM_OFF_CTRL, ctl);
      iam_peer_inst.send(b, ack);
      chk1(ack, exp);
      @(posedge clk);
      if (exp) begin
        wait_flag;
        chk1(irq, 1'b0);
        apb(1'b0, `IAM_OFF_STAT, 8'h00);
        chk8(q, {code, 3'b011});
        apb(1'b0, `IAM_OFF_DATA, 8'h00);
        chk8(q, b);
        apb(1'b1, `IAM_OFF_CTRL, ctl | 8'h80);
      end else begin
        apb(1'b0, `IAM_OFF_CTRL, 8'h00);
        chk1(q[7], 1'b0);
      end
      iam_peer_inst.stop;
      @(posedge clk);
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    failures = failures + 1;
    close_out;
  end
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    glb_irq_en = 1'b1;
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `IAM_OFF_CTRL, 8'h00);
    chk8(q, `IAM_RST_CTRL);
    apb(1'b0, `IAM_OFF_STAT, 8'h00);
    chk8(q, 8'hF8);
    apb(1'b0, `IAM_OFF_DATA, 8'h00);
    chk8(q, `IAM_RST_DATA);
    apb(1'b0, `IAM_OFF_ADDR, 8'h00);
    chk8(q, `IAM_RST_ADDR);
    apb(1'b0, 8'h10, 8'h00);
    chk1(err, 1'b1);
    chk8(q, 8'h00);
    apb(1'b1, `IAM_OFF_STAT, 8'h03);
    apb(1'b0, `IAM_OFF_STAT, 8'h00);
    chk8(q, 8'hFB);
    // Data write while no operation is pending must be refused and flagged
    apb(1'b1, `IAM_OFF_DATA, 8'h33);
    apb(1'b0, `IAM_OFF_CTRL, 8'h00);
    chk8(q, 8'h08);
    apb(1'b0, `IAM_OFF_DATA, 8'h00);
    chk8(q, 8'hFF);
    $display("test registers done");
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b1, `IAM_OFF_CTRL, 8'hA5);
      wait_flag;
      apb(1'b0, `IAM_OFF_STAT, 8'h00);
      chk8(q, {C_START, 3'b011});
      repeat (300) @(posedge clk);
      apb(1'b0, `IAM_OFF_STAT, 8'h00);
      chk8(q, {C_START, 3'b011});
      @(negedge clk);
      chk1(scl, 1'b0);
      chk1(irq, 1'b1);
      @(posedge clk);
      glb_irq_en <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk1(irq, 1'b0);
      @(posedge clk);
      glb_irq_en <= 1'b1;
      apb(1'b1, `IAM_OFF_DATA, (i != 0) ? 8'hB0 : 8'hA2);
      apb(1'b1, `IAM_OFF_CTRL, 8'h85);
      wait_flag;
      apb(1'b0, `IAM_OFF_STAT, 8'h00);
      chk8(q, {(i != 0) ? C_ANACK : C_AACK, 3'b011});
      chk8(p_byte, (i != 0) ? 8'hB0 : 8'hA2);
      if (i == 0) begin
        apb(1'b1, `IAM_OFF_DATA, 8'h5A);
        apb(1'b1, `IAM_OFF_CTRL, 8'h85);
        wait_flag;
        apb(1'b0, `IAM_OFF_STAT, 8'h00);
        chk8(q, {C_DACK, 3'b011});
        chk8(p_byte, 8'h5A);
      end
      apb(1'b1, `IAM_OFF_CTRL, 8'h95);
      repeat (600) @(posedge clk);
      apb(1'b0, `IAM_OFF_CTRL, 8'h00);
      chk8(q, 8'h05);
      $display("test master pass %0d done", i);
    end
    slave_case(8'h74, 8'h44, 8'h74, 1'b1, C_OWN);
    slave_case(8'h74, 8'h44, 8'h00, 1'b0, C_GC);
    slave_case(8'h75, 8'h44, 8'h00, 1'b1, C_GC);
    slave_case(8'h74, 8'h44, 8'h76, 1'b0, C_OWN);
    slave_case(8'h75, 8'h04, 8'h75, 1'b0, C_OWN);
    $display("test slave match done");
    close_out;
  end
endmodule // iam_top_tb
